// ### hw/etm_pkg.sv
package etm_pkg;
	// Register indices; the byte address is four times the index.
	localparam logic [2:0] IDX_CTRL = 3'h0;
	localparam logic [2:0] IDX_FLAGS = 3'h1;
	localparam logic [2:0] IDX_CONST_A = 3'h2;
	localparam logic [2:0] IDX_CONST_B = 3'h3;
	localparam logic [2:0] IDX_COUNT = 3'h4;
	// Reset values, and the count at which the counter wraps.
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [7:0] RST_FLAGS = 8'h10;
	localparam logic [7:0] RST_CONST = 8'hff;
	localparam logic [7:0] RST_COUNT = 8'h00;
	localparam logic [7:0] COUNT_MAX = 8'hff;
	// Field positions in timer_ctrl_reg.
	localparam int CTL_EN_B = 7;
	localparam int CTL_EN_A = 6;
	localparam int CTL_EN_W = 5;
	localparam int CTL_CLR_LSB = 3;
	localparam int CTL_SRC_LSB = 0;
	// Field positions in flags_outsel_reg.
	localparam int FLG_B = 7;
	localparam int FLG_A = 6;
	localparam int FLG_W = 5;
	localparam int FLG_FIXED = 4;
	localparam int OS_B_LSB = 2;
	localparam int OS_A_LSB = 0;
	// Source select codes.
	localparam logic [2:0] SRC_STOP0 = 3'h0;
	localparam logic [2:0] SRC_DIV8 = 3'h1;
	localparam logic [2:0] SRC_DIV64 = 3'h2;
	localparam logic [2:0] SRC_DIV1024 = 3'h3;
	localparam logic [2:0] SRC_STOP1 = 3'h4;
	localparam logic [2:0] SRC_EXT_RISE = 3'h5;
	localparam logic [2:0] SRC_EXT_FALL = 3'h6;
	localparam logic [2:0] SRC_EXT_BOTH = 3'h7;
	// Prescaler width and the bit that forms each internal source.
	localparam int PRESC_W = 10;
	localparam int DIV8_TAP = 2;
	localparam int DIV64_TAP = 5;
	localparam int DIV1024_TAP = 9;
	// Clear select codes.
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_MATCH_A = 2'h1;
	localparam logic [1:0] CLR_MATCH_B = 2'h2;
	localparam logic [1:0] CLR_EXT = 2'h3;
	// Output select codes; the code value is also the coincidence priority.
	localparam logic [1:0] OS_KEEP = 2'h0;
	localparam logic [1:0] OS_LOW = 2'h1;
	localparam logic [1:0] OS_HIGH = 2'h2;
	localparam logic [1:0] OS_TOGGLE = 2'h3;

	typedef struct packed {
		logic [7:0] ctrl;
		logic flag_a;
		logic flag_b;
		logic flag_w;
		logic seen_a;
		logic seen_b;
		logic seen_w;
		logic [3:0] out_sel;
		logic [7:0] const_a;
		logic [7:0] const_b;
		logic [7:0] cnt;
		logic [PRESC_W-1:0] presc;
		logic src_lvl;
		logic cin_s1;
		logic cin_s2;
		logic cin_d;
		logic rin_s1;
		logic rin_s2;
		logic rin_d;
		logic wave;
		logic wave_oe_n;
		logic irq_a;
		logic irq_b;
		logic irq_w;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} etm_state_type;
endpackage

// ### hw/etm_timer.sv
`timescale 1ns/1ps
module etm_timer
	import etm_pkg::*;
(
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// APB slave.
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pins.
	input wire logic ext_count_in,
	input wire logic ext_clear_in,
	output logic wave_out,
	output logic wave_out_oe_n,
	// Interrupt and transfer controllers.
	input wire logic xfer_ack_a,
	input wire logic xfer_ack_b,
	output logic match_irq_a,
	output logic match_irq_b,
	output logic wrap_irq
);

	etm_state_type st_ff;
	etm_state_type nxt_st;

	function automatic logic addr_is(input logic [7:0] a, input logic [2:0] idx);
		addr_is = (a == {3'h0, idx, 2'h0});
	endfunction

	logic bus_done;
	logic wr_done;
	logic rd_done;
	logic wr_ctrl;
	logic wr_flags;
	logic wr_const_a;
	logic wr_const_b;
	logic wr_cnt;
	logic rd_flags;
	logic mapped;
	logic [2:0] src;
	logic [1:0] clr_sel;
	logic int_lvl;
	logic inc_int;
	logic cin_rise;
	logic cin_fall;
	logic inc_ext;
	logic inc;
	logic match_a;
	logic match_b;
	logic ext_clr;
	logic clr;
	logic wrap;
	logic [1:0] os_a;
	logic [1:0] os_b;
	logic [1:0] act;
	logic [7:0] flags_rd;

	// The access phase always completes in its first cycle.
	assign bus_done = psel & penable & st_ff.pready;
	assign wr_done = bus_done & pwrite;
	assign rd_done = bus_done & ~pwrite;
	assign mapped = addr_is(paddr, IDX_CTRL) | addr_is(paddr, IDX_FLAGS) | addr_is(paddr, IDX_CONST_A)
		| addr_is(paddr, IDX_CONST_B) | addr_is(paddr, IDX_COUNT);
	assign wr_ctrl = wr_done & addr_is(paddr, IDX_CTRL);
	assign wr_flags = wr_done & addr_is(paddr, IDX_FLAGS);
	assign wr_const_a = wr_done & addr_is(paddr, IDX_CONST_A);
	assign wr_const_b = wr_done & addr_is(paddr, IDX_CONST_B);
	assign wr_cnt = wr_done & addr_is(paddr, IDX_COUNT);
	assign rd_flags = rd_done & addr_is(paddr, IDX_FLAGS);

	assign src = st_ff.ctrl[CTL_SRC_LSB +: 3];
	assign clr_sel = st_ff.ctrl[CTL_CLR_LSB +: 2];
	assign os_a = st_ff.out_sel[OS_A_LSB +: 2];
	assign os_b = st_ff.out_sel[OS_B_LSB +: 2];

	// Selected internal source level; stopped and external codes read as low.
	always_comb begin
		case (src)
			SRC_DIV8: int_lvl = st_ff.presc[DIV8_TAP];
			SRC_DIV64: int_lvl = st_ff.presc[DIV64_TAP];
			SRC_DIV1024: int_lvl = st_ff.presc[DIV1024_TAP];
			default: int_lvl = 1'b0;
		endcase
	end

	// Counting on the falling edge of the selected level means that a source change from high to low also
	// counts once, as does leaving an internal source that is high for an external one.
	assign inc_int = st_ff.src_lvl & ~int_lvl;
	assign cin_rise = st_ff.cin_s2 & ~st_ff.cin_d;
	assign cin_fall = ~st_ff.cin_s2 & st_ff.cin_d;
	// Narrow external pulses can slip between samples; the far end keeps them wide.
	assign inc_ext = ((src == SRC_EXT_RISE) & cin_rise) | ((src == SRC_EXT_FALL) & cin_fall)
		| ((src == SRC_EXT_BOTH) & (cin_rise | cin_fall));
	assign inc = inc_int | inc_ext;

	// A match is signalled as the equal count advances, not while it sits.
	assign match_a = inc & (st_ff.cnt == st_ff.const_a) & ~wr_const_a;
	assign match_b = inc & (st_ff.cnt == st_ff.const_b) & ~wr_const_b;
	assign ext_clr = (clr_sel == CLR_EXT) & st_ff.rin_s2 & ~st_ff.rin_d;
	assign clr = ((clr_sel == CLR_MATCH_A) & match_a) | ((clr_sel == CLR_MATCH_B) & match_b) | ext_clr;
	assign wrap = inc & ~clr & ~wr_cnt & (st_ff.cnt == COUNT_MAX);

	// Coincident matches take the higher code, which orders toggle, high, low, keep.
	always_comb begin
		if (match_a & match_b) begin
			act = (os_a > os_b) ? os_a : os_b;
		end else if (match_a) begin
			act = os_a;
		end else if (match_b) begin
			act = os_b;
		end else begin
			act = OS_KEEP;
		end
	end

	assign flags_rd = {st_ff.flag_b, st_ff.flag_a, st_ff.flag_w, 1'b1, st_ff.out_sel};

	always_comb begin
		nxt_st = st_ff;
		nxt_st.presc = st_ff.presc + 1'b1;
		nxt_st.src_lvl = int_lvl;
		nxt_st.cin_s1 = ext_count_in;
		nxt_st.cin_s2 = st_ff.cin_s1;
		nxt_st.cin_d = st_ff.cin_s2;
		nxt_st.rin_s1 = ext_clear_in;
		nxt_st.rin_s2 = st_ff.rin_s1;
		nxt_st.rin_d = st_ff.rin_s2;

		// Register writes.
		if (wr_ctrl) begin
			nxt_st.ctrl = pwdata[7:0];
		end
		if (wr_const_a) begin
			nxt_st.const_a = pwdata[7:0];
		end
		if (wr_const_b) begin
			nxt_st.const_b = pwdata[7:0];
		end
		if (wr_flags) begin
			nxt_st.out_sel = pwdata[OS_A_LSB +: 4];
		end

		// Counter: clear first, then a write, then the increment.
		if (clr) begin
			nxt_st.cnt = RST_COUNT;
		end else if (wr_cnt) begin
			nxt_st.cnt = pwdata[7:0];
		end else if (inc) begin
			nxt_st.cnt = st_ff.cnt + 1'b1;
		end

		// A read marks only flags that were set in the returned data.
		if (rd_flags) begin
			nxt_st.seen_a = st_ff.seen_a | st_ff.prdata[FLG_A];
			nxt_st.seen_b = st_ff.seen_b | st_ff.prdata[FLG_B];
			nxt_st.seen_w = st_ff.seen_w | st_ff.prdata[FLG_W];
		end

		// Clearing: a zero after a read, or transfer service for the match flags; writing one does nothing.
		if ((wr_flags & ~pwdata[FLG_A] & st_ff.seen_a) | xfer_ack_a) begin
			nxt_st.flag_a = 1'b0;
			nxt_st.seen_a = 1'b0;
		end
		if ((wr_flags & ~pwdata[FLG_B] & st_ff.seen_b) | xfer_ack_b) begin
			nxt_st.flag_b = 1'b0;
			nxt_st.seen_b = 1'b0;
		end
		if (wr_flags & ~pwdata[FLG_W] & st_ff.seen_w) begin
			nxt_st.flag_w = 1'b0;
			nxt_st.seen_w = 1'b0;
		end

		// Setting comes last so a coinciding event survives the clear.
		if (match_a) begin
			nxt_st.flag_a = 1'b1;
		end
		if (match_b) begin
			nxt_st.flag_b = 1'b1;
		end
		if (wrap) begin
			nxt_st.flag_w = 1'b1;
		end

		// Wave output.
		case (act)
			OS_LOW: nxt_st.wave = 1'b0;
			OS_HIGH: nxt_st.wave = 1'b1;
			OS_TOGGLE: nxt_st.wave = ~st_ff.wave;
			default: nxt_st.wave = st_ff.wave;
		endcase
		nxt_st.wave_oe_n = (nxt_st.out_sel == 4'h0);

		// Requests follow the next flag and enable so the lines change with the flags.
		nxt_st.irq_a = nxt_st.flag_a & nxt_st.ctrl[CTL_EN_A];
		nxt_st.irq_b = nxt_st.flag_b & nxt_st.ctrl[CTL_EN_B];
		nxt_st.irq_w = nxt_st.flag_w & nxt_st.ctrl[CTL_EN_W];

		// APB answer: ready in the first access cycle, data captured in setup.
		nxt_st.pready = psel & ~penable;
		nxt_st.pslverr = psel & ~penable & ~mapped;
		nxt_st.prdata = 32'h0;
		if (psel & ~penable & ~pwrite) begin
			if (addr_is(paddr, IDX_CTRL)) begin
				nxt_st.prdata = {24'h0, st_ff.ctrl};
			end else if (addr_is(paddr, IDX_FLAGS)) begin
				nxt_st.prdata = {24'h0, flags_rd};
			end else if (addr_is(paddr, IDX_CONST_A)) begin
				nxt_st.prdata = {24'h0, st_ff.const_a};
			end else if (addr_is(paddr, IDX_CONST_B)) begin
				nxt_st.prdata = {24'h0, st_ff.const_b};
			end else if (addr_is(paddr, IDX_COUNT)) begin
				nxt_st.prdata = {24'h0, st_ff.cnt};
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_ff <= '0;
			st_ff.ctrl <= RST_CTRL;
			st_ff.out_sel <= RST_FLAGS[3:0];
			st_ff.const_a <= RST_CONST;
			st_ff.const_b <= RST_CONST;
			st_ff.cnt <= RST_COUNT;
			st_ff.wave <= 1'b0;
			st_ff.wave_oe_n <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign prdata = st_ff.prdata;
	assign pready = st_ff.pready;
	assign pslverr = st_ff.pslverr;
	assign wave_out = st_ff.wave;
	assign wave_out_oe_n = st_ff.wave_oe_n;
	// Request lines are separate; the interrupt controller ranks A over B over wrap.
	assign match_irq_a = st_ff.irq_a;
	assign match_irq_b = st_ff.irq_b;
	assign wrap_irq = st_ff.irq_w;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_flags_read_set_a;
		rd_flags && st_ff.prdata[FLG_A];
	endsequence

	sequence s_flags_zero_a;
		wr_flags && !pwdata[FLG_A] && !xfer_ack_a && !match_a;
	endsequence

	// The idle edge and the setup edge of the following write lie between the read and the clearing write.
	a_flag_a_handshake: assert property (s_flags_read_set_a ##1 (!bus_done) [*2] ##1 s_flags_zero_a
		|=> !st_ff.flag_a) else $error("flag A not cleared after read and zero write");
	a_flag_a_guard: assert property ($fell(st_ff.flag_a) |-> $past(st_ff.seen_a) || $past(xfer_ack_a))
		else $error("flag A cleared without read or service");
	a_service_clears: assert property (xfer_ack_b && !match_b |=> !st_ff.flag_b)
		else $error("service did not clear flag B");
	a_wrap_sets: assert property (wrap |=> st_ff.flag_w && st_ff.cnt == 8'h00)
		else $error("wrap did not set its flag");
	a_wrap_no_service: assert property ($fell(st_ff.flag_w) |-> $past(wr_flags) && $past(st_ff.seen_w))
		else $error("wrap flag cleared without software");
	a_fixed_bit_one: assert property (rd_flags |-> prdata[FLG_FIXED])
		else $error("reserved flag bit read as zero");
	a_toggle_a: assert property (match_a && !match_b && os_a == OS_TOGGLE |=> wave_out != $past(wave_out))
		else $error("toggle on match A missing");
	// The enable is registered from the next selects, so it always agrees with the stored selects.
	a_pin_release: assert property (st_ff.out_sel == 4'h0 |-> wave_out_oe_n)
		else $error("wave pin driven with all selects zero");
	a_irq_level: assert property (match_irq_a == (st_ff.flag_a && st_ff.ctrl[CTL_EN_A]))
		else $error("request A disagrees with flag and enable");
	a_clear_wins: assert property (wr_cnt && clr |=> st_ff.cnt == 8'h00)
		else $error("count write beat a clear");
	a_write_wins: assert property (wr_cnt && !clr |=> st_ff.cnt == $past(pwdata[7:0]))
		else $error("count write lost to increment");
	a_const_write_mask: assert property (wr_const_a |=> !$rose(st_ff.flag_a) || $past(xfer_ack_a))
		else $error("match A during constant write");
	a_set_beats_clear: assert property (match_b |=> st_ff.flag_b)
		else $error("match B flag lost to a clear");

endmodule

// ### test/etm_svc_model.sv
`timescale 1ns/1ps
module etm_svc_model (
	// Clock and reset.
	input wire logic pclk,
	input wire logic presetn,
	// Service switch from the bench.
	input wire logic svc_en,
	// Requests in, service pulses out.
	input wire logic match_irq_a,
	input wire logic match_irq_b,
	output logic xfer_ack_a,
	output logic xfer_ack_b
);
	// A is served before B; the wrap request is never served by transfers, so it is not even watched.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			xfer_ack_a <= 1'b0;
			xfer_ack_b <= 1'b0;
		end else begin
			xfer_ack_a <= svc_en && match_irq_a && !xfer_ack_a && !xfer_ack_b;
			xfer_ack_b <= svc_en && !match_irq_a && match_irq_b && !xfer_ack_a && !xfer_ack_b;
		end
	end
endmodule

// ### test/test_eight_bit_match_timer.sv
`timescale 1ns/1ps
module test_eight_bit_match_timer
	import etm_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic ext_count_in = 1'b0;
	logic ext_clear_in = 1'b0;
	logic wave_out;
	logic wave_out_oe_n;
	logic xfer_ack_a;
	logic xfer_ack_b;
	logic match_irq_a;
	logic match_irq_b;
	logic wrap_irq;
	logic svc_en = 1'b0;
	logic err_seen;
	logic [2:0] irqs;
	int fails = 0;
	int n_compared = 0;

	assign irqs = {wrap_irq, match_irq_b, match_irq_a};

	always #5 pclk = ~pclk;

	etm_timer dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.ext_count_in(ext_count_in), .ext_clear_in(ext_clear_in), .wave_out(wave_out),
		.wave_out_oe_n(wave_out_oe_n), .xfer_ack_a(xfer_ack_a), .xfer_ack_b(xfer_ack_b),
		.match_irq_a(match_irq_a), .match_irq_b(match_irq_b), .wrap_irq(wrap_irq));

	etm_svc_model svc_u (.pclk(pclk), .presetn(presetn), .svc_en(svc_en), .match_irq_a(match_irq_a),
		.match_irq_b(match_irq_b), .xfer_ack_a(xfer_ack_a), .xfer_ack_b(xfer_ack_b));

	function automatic logic [7:0] ra(input logic [2:0] idx);
		return {3'h0, idx, 2'b00};
	endfunction

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("Error %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One transfer, then an idle edge so that a following setup never lands in the same time step.
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] rd);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (n >= 20) fails++;
		rd = prdata;
		err_seen = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic wr(input logic [2:0] idx, input logic [7:0] d);
		logic [31:0] rd;
		apb(1'b1, ra(idx), d, rd);
	endtask

	task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] rd;
		apb(1'b0, a, 8'h00, rd);
		chk(what, rd, exp);
	endtask

	task automatic wait_irq(input int b);
		int n;
		n = 0;
		while (irqs[b] !== 1'b1 && n < 300) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 300) fails++;
	endtask

	task automatic pulse(input logic clr);
		if (clr) ext_clear_in <= 1'b1;
		else ext_count_in <= 1'b1;
		repeat (3) @(posedge pclk);
		ext_clear_in <= 1'b0;
		ext_count_in <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask

	task automatic t_reset();
		chk("wave", 32'(wave_out), 32'h0);
		chk("wave_oe_n", 32'(wave_out_oe_n), 32'h1);
		rdc("ctrl", ra(IDX_CTRL), 32'h00);
		rdc("flags", ra(IDX_FLAGS), 32'h10);
		rdc("const_a", ra(IDX_CONST_A), 32'hff);
		rdc("const_b", ra(IDX_CONST_B), 32'hff);
		rdc("count", ra(IDX_COUNT), 32'h00);
		rdc("unmapped", 8'h14, 32'h0);
		chk("slverr", 32'(err_seen), 32'h1);
	endtask

	task automatic t_flags();
		wr(IDX_FLAGS, 8'hff);
		rdc("flags", ra(IDX_FLAGS), 32'h1f);
		chk("wave_oe_n", 32'(wave_out_oe_n), 32'h0);
		wr(IDX_FLAGS, 8'h00);
		rdc("flags", ra(IDX_FLAGS), 32'h10);
		chk("wave_oe_n", 32'(wave_out_oe_n), 32'h1);
	endtask

	task automatic t_match_a();
		wr(IDX_CONST_A, 8'h02);
		wr(IDX_FLAGS, 8'h03);
		wr(IDX_CTRL, 8'h49);
		wait_irq(0);
		chk("wave", 32'(wave_out), 32'h1);
		rdc("count", ra(IDX_COUNT), 32'h0);
		wr(IDX_CTRL, 8'h40);
		wr(IDX_FLAGS, 8'h03);
		rdc("flags", ra(IDX_FLAGS), 32'h53);
		wr(IDX_FLAGS, 8'h03);
		rdc("flags", ra(IDX_FLAGS), 32'h13);
		chk("irq_a", 32'(match_irq_a), 32'h0);
	endtask

	// Equal constants make both matches coincide; toggle must beat the high drive.
	task automatic t_service();
		svc_en <= 1'b1;
		wr(IDX_CONST_A, 8'hfe);
		wr(IDX_CONST_B, 8'hfe);
		wr(IDX_FLAGS, 8'h0e);
		wr(IDX_COUNT, 8'hfd);
		wr(IDX_CTRL, 8'he1);
		wait_irq(2);
		repeat (8) @(posedge pclk);
		chk("irq_a", 32'(match_irq_a), 32'h0);
		chk("irq_b", 32'(match_irq_b), 32'h0);
		chk("wrap_irq", 32'(wrap_irq), 32'h1);
		chk("wave", 32'(wave_out), 32'h0);
		rdc("flags", ra(IDX_FLAGS), 32'h3e);
		wr(IDX_CTRL, 8'h00);
		svc_en <= 1'b0;
		wr(IDX_FLAGS, 8'h0e);
		rdc("flags", ra(IDX_FLAGS), 32'h1e);
	endtask

	task automatic t_ext();
		for (int i = 0; i < 3; i++) begin
			wr(IDX_CTRL, 8'h1d + 8'(i));
			wr(IDX_COUNT, 8'h00);
			repeat (4) pulse(1'b0);
			repeat (4) @(posedge pclk);
			rdc("count", ra(IDX_COUNT), (i == 2) ? 32'h8 : 32'h4);
		end
		pulse(1'b1);
		repeat (4) @(posedge pclk);
		rdc("count", ra(IDX_COUNT), 32'h0);
	endtask

	task automatic close_out();
		if (fails == 0 && n_compared > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		t_reset();
		t_flags();
		t_match_a();
		t_service();
		t_ext();
		close_out();
	end

	initial begin
		#200000;
		fails++;
		close_out();
	end
endmodule
